//--- common/sstx_params.svh
// Purpose: offsets, field positions and reset values for the secondary port tx slot block
// Assumes: 8-bit configuration registers on a byte-addressed register port
// Notes:   included by bare name
`ifndef SSTX_PARAMS_SVH
`define SSTX_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSTX_CH7_CONFIG_OFS   8'h24
`define SSTX_CH8_CONFIG_OFS   8'h25

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSTX_CH7_CONFIG_RST   8'h06
`define SSTX_CH8_CONFIG_RST   8'h07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSTX_SLOT_LSB         0
`define SSTX_SLOT_MSB         4
`define SSTX_CH7_SRC_LSB      5
`define SSTX_CH7_SRC_MSB      6
`define SSTX_CH8_SRC_BIT      5
`define SSTX_CH7_RW_MASK      8'h7F
`define SSTX_CH8_RW_MASK      8'h3F

// ----------------------------------------------------------------
// slot numbering
// ----------------------------------------------------------------
`define SSTX_HALF_SLOTS       16

`endif

//--- common/sstx_pkg.sv
// Purpose: types shared by the secondary port tx slot block
// Assumes: nothing
// Notes:   constants live in sstx_params.svh
package sstx_pkg;

    typedef enum logic [1:0] {
        SSTX_FMT_TDM = 2'h0,
        SSTX_FMT_I2S = 2'h1,
        SSTX_FMT_LJ  = 2'h2
    } sstx_fmt_e;

    typedef enum logic [1:0] {
        SSTX_CH7_OFF     = 2'h0,
        SSTX_CH7_BATTEMP = 2'h1,
        SSTX_CH7_ECHO    = 2'h2,
        SSTX_CH7_RSVD    = 2'h3
    } sstx_ch7_src_e;

    typedef logic [4:0] sstx_slot_t;

endpackage

//--- design/sstx_slot_pick.sv
// Purpose: one transmit channel: slot match and bit pick for the current frame position
// Assumes: frame position comes from the same clock domain
// Notes:   purely combinational
`timescale 1ns/1ps
module sstx_slot_pick #(
    parameter int WL = 32
) (
    input  wire logic                  enable,    // channel has a source
    input  wire sstx_pkg::sstx_slot_t  slot_idx,  // assigned slot
    input  wire sstx_pkg::sstx_slot_t  cur_slot,  // slot now on the line
    input  wire logic                  cur_valid, // position lies inside a slot
    input  wire logic [$clog2(WL)-1:0] bit_pos,   // bit within the slot, 0 = msb
    input  wire logic [WL-1:0]         word,      // data word for the channel
    output logic                       drive,     // channel owns this bit
    output logic                       bit_out    // bit to send
);
    import sstx_pkg::*;

    always_comb begin
        drive   = enable && cur_valid && (cur_slot == slot_idx);
        bit_out = word[($clog2(WL))'(WL - 1) - bit_pos];
    end

endmodule

//--- design/sstx_slot_tx.sv
// Purpose: secondary serial port transmit channels 7 and 8, slot placement and source select
// Assumes: bit clock and frame sync come from the far end, slower than a quarter of clock
// Notes:   data changes after the falling bit-clock edge, msb first, no one-bit i2s delay
`timescale 1ns/1ps
`include "sstx_params.svh"

module sstx_slot_tx #(
    parameter int WL = 32
) (
    input  wire logic                   clock,                       // system clock, 25 MHz
    input  wire logic                   sys_rst,                     // sync reset, high
    input  wire logic                   reg_wr,                      // register write strobe
    input  wire logic                   reg_rd,                      // register read strobe
    input  wire logic [7:0]             reg_addr,                    // register address
    input  wire logic [7:0]             reg_wdata,                   // write data
    output logic [7:0]                  reg_rdata,                   // read data
    input  wire sstx_pkg::sstx_fmt_e    frame_format,                // tdm, i2s or lj
    input  wire logic                   bclk,                        // bit clock pin
    input  wire logic                   fsync,                       // frame sync pin
    input  wire logic [WL/2-1:0]        battery_half_word,           // battery sample
    input  wire logic [WL/2-1:0]        thermal_sense_half_word,     // temperature sample
    input  wire logic [WL/2-1:0]        echo_reference_first_half,   // echo ref, ch 1
    input  wire logic [WL/2-1:0]        echo_reference_second_half,  // echo ref, ch 2
    input  wire logic [WL-1:0]          interchip_limiter_alignment, // limiter word
    output logic                        sdout,                       // serial data out
    output logic                        sdout_oe                     // data pin drive enable
);
    import sstx_pkg::*;

    localparam int LW = $clog2(WL);
    localparam int PW = LW + 6;

    if (WL < 8 || (1 << LW) != WL) begin : g_wl_check
        $error("WL must be a power of two of at least 8");
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [6:0] ch7_cfg;
    logic [5:0] ch8_cfg;
    logic [7:0] next_reg_rdata;
    logic [6:0] next_ch7_cfg;
    logic [5:0] next_ch8_cfg;

    always_comb begin
        next_ch7_cfg   = ch7_cfg;
        next_ch8_cfg   = ch8_cfg;
        next_reg_rdata = reg_rdata;
        if (reg_wr && reg_addr == `SSTX_CH7_CONFIG_OFS) begin
            next_ch7_cfg = reg_wdata[6:0];
        end
        if (reg_wr && reg_addr == `SSTX_CH8_CONFIG_OFS) begin
            next_ch8_cfg = reg_wdata[5:0];
        end
        if (reg_rd) begin
            case (reg_addr)
                `SSTX_CH7_CONFIG_OFS: next_reg_rdata = {1'b0, ch7_cfg} & `SSTX_CH7_RW_MASK;
                `SSTX_CH8_CONFIG_OFS: next_reg_rdata = {2'b00, ch8_cfg} & `SSTX_CH8_RW_MASK;
                default:              next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ch7_cfg   <= 7'(`SSTX_CH7_CONFIG_RST & `SSTX_CH7_RW_MASK);
            ch8_cfg   <= 6'(`SSTX_CH8_CONFIG_RST);
            reg_rdata <= 8'h00;
        end else begin
            ch7_cfg   <= next_ch7_cfg;
            ch8_cfg   <= next_ch8_cfg;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [1:0] bclk_sync;
    logic [1:0] fs_sync;
    logic       bclk_prev;
    logic       fs_prev;
    logic       restart;
    logic       half;
    logic [PW-1:0] pos;
    logic       next_bclk_prev;
    logic       next_fs_prev;
    logic       next_restart;
    logic       next_half;
    logic [PW-1:0] next_pos;
    logic       next_sdout;
    logic       next_sdout_oe;
    logic       bclk_rise;
    logic       bclk_fall;
    logic [PW-1:0] p;
    logic [PW-LW-1:0] slot_raw;
    sstx_slot_t cur_slot;
    logic       cur_valid;
    logic [LW-1:0] bit_pos;

    // ----------------------------------------------------------------
    // channel words and slot pickers
    // ----------------------------------------------------------------
    sstx_ch7_src_e ch7_src;
    logic [WL-1:0] ch7_word;
    logic          ch7_en;
    logic          ch8_en;
    logic          ch7_drive;
    logic          ch7_bit;
    logic          ch8_drive;
    logic          ch8_bit;

    always_comb begin
        ch7_src = sstx_ch7_src_e'(ch7_cfg[`SSTX_CH7_SRC_MSB:`SSTX_CH7_SRC_LSB]);
        case (ch7_src)
            SSTX_CH7_BATTEMP: ch7_word = {battery_half_word, thermal_sense_half_word};
            SSTX_CH7_ECHO:    ch7_word = {echo_reference_first_half, echo_reference_second_half};
            default:          ch7_word = '0;
        endcase
        ch7_en = (ch7_src == SSTX_CH7_BATTEMP) || (ch7_src == SSTX_CH7_ECHO);
        ch8_en = ch8_cfg[`SSTX_CH8_SRC_BIT];
    end

    sstx_slot_pick #(.WL(WL)) u_ch7 (
        .enable    (ch7_en),
        .slot_idx  (ch7_cfg[`SSTX_SLOT_MSB:`SSTX_SLOT_LSB]),
        .cur_slot  (cur_slot),
        .cur_valid (cur_valid),
        .bit_pos   (bit_pos),
        .word      (ch7_word),
        .drive     (ch7_drive),
        .bit_out   (ch7_bit)
    );

    sstx_slot_pick #(.WL(WL)) u_ch8 (
        .enable    (ch8_en),
        .slot_idx  (ch8_cfg[`SSTX_SLOT_MSB:`SSTX_SLOT_LSB]),
        .cur_slot  (cur_slot),
        .cur_valid (cur_valid),
        .bit_pos   (bit_pos),
        .word      (interchip_limiter_alignment),
        .drive     (ch8_drive),
        .bit_out   (ch8_bit)
    );

    // ----------------------------------------------------------------
    // frame position and serial output
    // ----------------------------------------------------------------
    always_comb begin
        bclk_rise      = bclk_sync[1] && !bclk_prev;
        bclk_fall      = !bclk_sync[1] && bclk_prev;
        next_bclk_prev = bclk_sync[1];
        next_fs_prev   = fs_prev;
        next_restart   = restart;
        next_half      = half;
        next_pos       = pos;
        next_sdout     = sdout;
        next_sdout_oe  = sdout_oe;
        p              = restart ? '0 : PW'(pos + 1'b1);
        slot_raw       = p[PW-1:LW];
        bit_pos        = p[LW-1:0];
        if (frame_format == SSTX_FMT_TDM) begin
            cur_slot  = slot_raw[4:0];
            cur_valid = (slot_raw < (PW-LW)'(32));
        end else begin
            cur_slot  = {half, slot_raw[3:0]};
            cur_valid = (slot_raw < (PW-LW)'(`SSTX_HALF_SLOTS));
        end
        if (bclk_rise) begin
            next_fs_prev = fs_sync[1];
            if (fs_sync[1] && !fs_prev) begin
                next_restart = 1'b1;
                next_half    = 1'b0;
            end else if (!fs_sync[1] && fs_prev && frame_format != SSTX_FMT_TDM) begin
                next_restart = 1'b1;
                next_half    = 1'b1;
            end
        end
        if (bclk_fall) begin
            next_pos     = (p == '1) ? pos : p;
            next_restart = 1'b0;
            next_sdout_oe = ch7_drive || ch8_drive;
            next_sdout    = ch7_drive ? ch7_bit : (ch8_drive ? ch8_bit : 1'b0);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bclk_sync <= 2'h0;
            fs_sync   <= 2'h0;
            bclk_prev <= 1'b0;
            fs_prev   <= 1'b0;
            restart   <= 1'b0;
            half      <= 1'b0;
            // parked at its saturation value, one below all ones: no slot is valid before the first frame sync
            pos       <= {{(PW-1){1'b1}}, 1'b0};
            sdout     <= 1'b0;
            sdout_oe  <= 1'b0;
        end else begin
            bclk_sync <= {bclk_sync[0], bclk};
            fs_sync   <= {fs_sync[0], fsync};
            bclk_prev <= next_bclk_prev;
            fs_prev   <= next_fs_prev;
            restart   <= next_restart;
            half      <= next_half;
            pos       <= next_pos;
            sdout     <= next_sdout;
            sdout_oe  <= next_sdout_oe;
        end
    end

endmodule

//--- tb/sstx_slot_tx_checker.sv
// Purpose: concurrent checks on the register port and data pin of sstx_slot_tx
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module sstx_slot_tx_checker (
    input wire logic       clock,     // system clock
    input wire logic       sys_rst,   // sync reset
    input wire logic       reg_wr,    // write strobe
    input wire logic       reg_rd,    // read strobe
    input wire logic [7:0] reg_addr,  // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic [7:0] reg_rdata, // read data
    input wire logic       sdout,     // serial data
    input wire logic       sdout_oe   // data pin enable
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    property p_ch7_rsvd;
        reg_rd && reg_addr == 8'h24 |=> !reg_rdata[7];
    endproperty
    a_ch7_rsvd: assert property (p_ch7_rsvd) else $error("ch7 bit 7 read high");
    property p_ch8_rsvd;
        reg_rd && reg_addr == 8'h25 |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_ch8_rsvd: assert property (p_ch8_rsvd) else $error("ch8 bits 7:6 read high");
    property p_ch7_src;
        reg_wr && reg_addr == 8'h24 ##1 reg_rd && reg_addr == 8'h24
            |=> reg_rdata[6:5] == $past(reg_wdata[6:5], 2);
    endproperty
    a_ch7_src: assert property (p_ch7_src) else $error("ch7 source not stored");
    property p_ch7_slot;
        reg_wr && reg_addr == 8'h24 ##1 reg_rd && reg_addr == 8'h24
            |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 2);
    endproperty
    a_ch7_slot: assert property (p_ch7_slot) else $error("ch7 slot not stored");
    property p_ch8_src;
        reg_wr && reg_addr == 8'h25 ##1 reg_rd && reg_addr == 8'h25
            |=> reg_rdata[5] == $past(reg_wdata[5], 2);
    endproperty
    a_ch8_src: assert property (p_ch8_src) else $error("ch8 source not stored");
    property p_ch8_slot;
        reg_wr && reg_addr == 8'h25 ##1 reg_rd && reg_addr == 8'h25
            |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 2);
    endproperty
    a_ch8_slot: assert property (p_ch8_slot) else $error("ch8 slot not stored");
    property p_rst_out;
        $fell(sys_rst) |-> reg_rdata == 8'h00 && !sdout_oe;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not idle after reset");
    property p_idle;
        !sdout_oe |-> !sdout;
    endproperty
    a_idle: assert property (p_idle) else $error("data high while released");
endmodule
bind sstx_slot_tx sstx_slot_tx_checker i_chk (.clock(clock), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sdout(sdout), .sdout_oe(sdout_oe));

//--- tb/sstx_host_model.sv
// Purpose: receiving host: makes bit clock and frame sync, samples the data pin
// Assumes: frame of 32 slots, bit clock stands low between frames
// Notes:   bit n is sampled just before the fall that launches bit n+1
`timescale 1ns/1ps
module sstx_host_model #(
    parameter int WL = 8
) (
    output logic      bclk,    // bit clock, 320 ns
    output logic      fsync,   // frame sync, high on first half
    input  wire logic sdout,   // data from device
    input  wire logic sdout_oe // drive enable from device
);
    localparam int NB = 32 * WL;
    logic [NB-1:0] cap_oe;
    logic [NB-1:0] cap_d;
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
    end
    task automatic run_frame();
        for (int i = 0; i <= NB; i++) begin
            bclk <= 1'b0;
            fsync <= (i < NB / 2);
            #160;
            bclk <= 1'b1;
            #160;
            if (i > 0) begin
                cap_oe[i-1] = sdout_oe;
                cap_d[i-1] = sdout;
            end
        end
        bclk <= 1'b0;
        fsync <= 1'b0;
    endtask
endmodule

//--- tb/sstx_slot_tx_tb_top.sv
// Purpose: register and frame tests of sstx_slot_tx
// Assumes: 8-bit slots to keep frames short
// Notes:   expected bits worked out from slot index = bit position / WL
`timescale 1ns/1ps
module sstx_slot_tx_tb_top;
    import sstx_pkg::*;
    localparam int WL = 8;
    localparam int NB = 32 * WL;
    localparam logic [7:0] W_BAT = 8'hA5;
    localparam logic [7:0] W_ECHO = 8'hC3;
    localparam logic [7:0] W_LIM = 8'h96;
    logic        clock;
    logic        sys_rst;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    sstx_fmt_e   frame_format;
    logic        bclk;
    logic        fsync;
    logic        sdout;
    logic        sdout_oe;
    logic [7:0]  v;
    logic [1:0]  e;
    int          err_total;
    int          checks;
    int          cyc;
    sstx_fmt_e   fmt [4] = '{SSTX_FMT_TDM, SSTX_FMT_I2S, SSTX_FMT_LJ, SSTX_FMT_TDM};
    logic [7:0]  c7 [4] = '{8'h23, 8'h51, 8'h65, 8'h02};
    logic [7:0]  c8 [4] = '{8'h3F, 8'h20, 8'h30, 8'h02};
    sstx_slot_tx #(.WL(WL)) i_dut (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .frame_format(frame_format), .bclk(bclk), .fsync(fsync),
        .battery_half_word(W_BAT[7:4]), .thermal_sense_half_word(W_BAT[3:0]),
        .echo_reference_first_half(W_ECHO[7:4]), .echo_reference_second_half(W_ECHO[3:0]),
        .interchip_limiter_alignment(W_LIM), .sdout(sdout), .sdout_oe(sdout_oe));
    sstx_host_model #(.WL(WL)) i_host (.bclk(bclk), .fsync(fsync), .sdout(sdout),
        .sdout_oe(sdout_oe));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results();
        $display("mismatches %0d of %0d checks", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // both tasks start right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        // read data stands until the next read strobe
        @(posedge clock);
        d = reg_rdata;
    endtask
    function automatic logic [1:0] exp_bit(input logic [7:0] r7, input logic [7:0] r8,
                                           input int p);
        int idx;
        int b;
        idx = p / WL;
        b = WL - 1 - p % WL;
        if ((r7[6:5] == 2'h1 || r7[6:5] == 2'h2) && idx == int'(r7[4:0]))
            return {1'b1, r7[5] ? W_BAT[b] : W_ECHO[b]};
        if (r8[5] && idx == int'(r8[4:0]))
            return {1'b1, W_LIM[b]};
        return 2'h0;
    endfunction
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    initial begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        frame_format = SSTX_FMT_TDM;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h24, v);
        check("ch7 reset", v, 8'h06);
        rd(8'h25, v);
        check("ch8 reset", v, 8'h07);
        rd(8'h26, v);
        check("unmapped", v, 8'h00);
        wr(8'h24, 8'h7F);
        rd(8'h24, v);
        check("ch7 reserved", v, 8'h7F);
        wr(8'h25, 8'h3F);
        rd(8'h25, v);
        check("ch8 reserved", v, 8'h3F);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            frame_format <= fmt[k];
            wr(8'h24, c7[k]);
            @(posedge clock);
            wr(8'h25, c8[k]);
            i_host.run_frame();
            for (int p = 0; p < NB; p++) begin
                e = exp_bit(c7[k], c8[k], p);
                check("slot enable", {7'h00, i_host.cap_oe[p]}, {7'h00, e[1]});
                check("slot data", {7'h00, i_host.cap_d[p]}, {7'h00, e[0]});
            end
        end
        // mid-run reset restores the defaults and silences both channels
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'h24, v);
        check("ch7 reset again", v, 8'h06);
        rd(8'h25, v);
        check("ch8 reset again", v, 8'h07);
        i_host.run_frame();
        for (int p = 0; p < NB; p++) begin
            check("idle after reset", {7'h00, i_host.cap_oe[p]}, 8'h00);
        end
        results();
    end
endmodule
